// ==== ddr3_dram_device.sv ====
// DRAM device end: command decode, bank state, mode registers and bursts
`timescale 1ns/1ps
module ddr3_dram_device #(
  parameter int CAS_LATENCY = ddr3_link_pkg::CAS_LAT,
  parameter int MEM_WORDS = 64
) (
  input wire logic resetLinkN, // Link reset, active low
  ddr3_link_if.dev link, // Pins from the controller
  output logic [ddr3_link_pkg::NUM_BANKS-1:0] bankOpen, // Open banks
  output logic powerDown // In power-down
);
  import ddr3_link_pkg::*;
  typedef enum logic [1:0] {IDLE, WAIT_LAT, READ_BURST, WRITE_BURST} st_type;
  localparam int MW = $clog2(MEM_WORDS);
  st_type state_q;
  logic [ADDR_W-1:0] mr_q [MR_NUM];
  logic [ADDR_W-1:0] row_q [NUM_BANKS];
  logic [DQ_W-1:0] mem_q [MEM_WORDS];
  logic [NUM_BANKS-1:0] open_q;
  logic cke_q;
  logic pd_q;
  logic [BANK_W-1:0] burstBank_q;
  logic [COL_W-1:0] col_q;
  logic isWrite_q;
  logic autoPre_q;
  logic [3:0] beats_q;
  logic [3:0] beatCnt_q;
  logic [5:0] lat_q;
  logic [DQ_W-1:0] dqOut_q;
  logic dqOe_q;
  logic dqs_q;
  wire ckEn = cke_q;
  // Command code built from the sampled control pins
  wire [3:0] cmdCode = {link.csN, link.rasN, link.casN, link.weN};
  wire cmdValid = ckEn && !link.csN;
  wire isAct = cmdValid && cmdCode == CMD_ACT;
  wire isPre = cmdValid && cmdCode == CMD_PRE;
  wire isRd = cmdValid && cmdCode == CMD_RD;
  wire isWr = cmdValid && cmdCode == CMD_WR;
  wire isMrs = cmdValid && cmdCode == CMD_MRS;
  wire [1:0] alSel = mr_q[1][MR1_AL_POS +: 2];
  wire [5:0] addLat = alSel == AL_CL1 ? 6'(CAS_LATENCY - 1) :
                      alSel == AL_CL2 ? 6'(CAS_LATENCY - 2) : 6'h0;
  wire [5:0] totLat = 6'(addLat + 6'(CAS_LATENCY));
  // Burst length: fixed 4, fixed 8, or chop on the fly via A12
  wire [1:0] blSel = mr_q[0][MR0_BL_POS +: 2];
  wire chop = blSel == 2'h2 ||
              (blSel == 2'h1 && !link.addr[BC_BIT]);
  wire [3:0] newBeats = chop ? 4'(BL_CHOP) : 4'(BL_FULL);
  wire ilv = mr_q[0][MR0_BT_POS];
  wire [2:0] beatPos = beat_idx(col_q[2:0], beatCnt_q[2:0], ilv);
  wire [MW-1:0] memIdx = MW'({burstBank_q, col_q[COL_W-1:3], beatPos});
  wire allIdle = open_q == '0 && state_q == IDLE;
  wire lastBeat = beatCnt_q == beats_q - 4'h1;
  // Clock enable sample and power-down entry on the link clock
  always_ff @(posedge link.ck) begin
    if (!resetLinkN) begin
      cke_q <= 1'b1;
      pd_q <= 1'b0;
    end else begin
      cke_q <= link.cke;
      if (!link.cke && cke_q && allIdle)
        pd_q <= 1'b1;
      else if (link.cke)
        pd_q <= 1'b0;
    end
  end
  // Bank state and mode registers
  always_ff @(posedge link.ck) begin
    if (!resetLinkN) begin
      open_q <= '0;
      for (int i = 0; i < MR_NUM; i++)
        mr_q[i] <= MR_RESET;
      for (int i = 0; i < NUM_BANKS; i++)
        row_q[i] <= '0;
    end else begin
      if (isMrs)
        mr_q[link.ba[1:0]] <= link.addr;
      if (isAct) begin
        open_q[link.ba] <= 1'b1;
        row_q[link.ba] <= link.addr;
      end
      if (isPre) begin
        if (link.addr[AP_BIT])
          open_q <= '0;
        else
          open_q[link.ba] <= 1'b0;
      end
      if (state_q != IDLE && lastBeat && autoPre_q && ckEn &&
          state_q != WAIT_LAT)
        open_q[burstBank_q] <= 1'b0;
    end
  end
  // Burst sequencer: latency wait, then one beat per link clock, one strobe edge each
  always_ff @(posedge link.ck) begin
    if (!resetLinkN) begin
      state_q <= IDLE;
      burstBank_q <= '0;
      col_q <= '0;
      isWrite_q <= 1'b0;
      autoPre_q <= 1'b0;
      beats_q <= 4'h0;
      beatCnt_q <= 4'h0;
      lat_q <= 6'h0;
    end else if (ckEn) begin
      unique case (state_q)
        IDLE: begin
          if ((isRd || isWr) && open_q[link.ba]) begin
            burstBank_q <= link.ba;
            col_q <= col_of(link.addr);
            isWrite_q <= isWr;
            autoPre_q <= link.addr[AP_BIT];
            beats_q <= newBeats;
            beatCnt_q <= 4'h0;
            lat_q <= totLat;
            state_q <= WAIT_LAT;
          end
        end
        WAIT_LAT: begin
          lat_q <= lat_q - 6'h1;
          // Leave one cycle early: the first beat launches from a flop
          if (lat_q <= 6'h2)
            state_q <= isWrite_q ? WRITE_BURST : READ_BURST;
        end
        READ_BURST, WRITE_BURST: begin
          beatCnt_q <= beatCnt_q + 4'h1;
          if (lastBeat)
            state_q <= IDLE;
        end
      endcase
    end
  end
  // Data path; memory writes sample the bus at the beat
  always_ff @(posedge link.ck) begin
    if (!resetLinkN) begin
      dqOut_q <= '0;
      dqOe_q <= 1'b0;
      dqs_q <= 1'b0;
    end else if (ckEn) begin
      dqOe_q <= state_q == READ_BURST;
      dqs_q <= state_q == READ_BURST ? ~dqs_q : 1'b0;
      if (state_q == READ_BURST)
        dqOut_q <= mem_q[memIdx];
      if (state_q == WRITE_BURST)
        mem_q[memIdx] <= link.dq;
    end
  end
  assign link.dqDev = dqOut_q;
  assign link.dqDevOe = dqOe_q;
  assign link.dqsDev = dqs_q;
  assign link.dqsDevOe = dqOe_q;
  assign bankOpen = open_q;
  assign powerDown = pd_q;
endmodule

// ==== ddr3_link_chk.sv ====
// Link protocol checker for the DRAM command port
`timescale 1ns/1ps
module ddr3_link_chk (
  input wire logic ck, // Link clock
  input wire logic resetLinkN, // Link reset, active low
  input wire logic cke, // Clock enable
  input wire logic csN, // Chip select
  input wire logic rasN, // Row strobe
  input wire logic casN, // Column strobe
  input wire logic weN, // Write enable
  input wire logic [ddr3_link_pkg::BANK_W-1:0] ba, // Bank
  input wire logic [ddr3_link_pkg::ADDR_W-1:0] addr, // Address
  input wire logic dqs, // Resolved strobe
  input wire logic dqsDevOe, // Device strobe enable
  input wire logic [ddr3_link_pkg::NUM_BANKS-1:0] bankOpen, // Open banks
  input wire logic powerDown // Power-down flag
);
  import ddr3_link_pkg::*;
  // ====
  // Command code as sampled on the pins
  wire [3:0] cmd = {csN, rasN, casN, weN};
  default clocking cb @(posedge ck); endclocking
  default disable iff (!resetLinkN);
  // ====
  // Bank state follows only decoded, enabled commands
  a_open_on_act: assert property (
    (bankOpen & ~$past(bankOpen)) != '0 |-> $past(cmd) == CMD_ACT &&
    $past(cke) && (bankOpen & ~$past(bankOpen)) == (8'h01 << $past(ba)))
    else $error("bank opened without activate to it");
  a_cs_masks: assert property (
    $past(csN) |-> (bankOpen & ~$past(bankOpen)) == '0)
    else $error("bank opened while deselected");
  a_pre_all: assert property (
    $past(cmd) == CMD_PRE && $past(addr[AP_BIT]) && $past(cke)
    |-> bankOpen == '0) else $error("precharge all left a bank open");
  a_pre_one: assert property (
    $past(cmd) == CMD_PRE && !$past(addr[AP_BIT]) && $past(cke)
    |-> bankOpen == ($past(bankOpen) & ~(8'h01 << $past(ba))))
    else $error("single precharge hit wrong banks");
  // Strobe toggles each beat; burst is four to eight beats long
  a_dqs_toggle: assert property (
    dqsDevOe && $past(dqsDevOe) |-> dqs != $past(dqs))
    else $error("strobe did not toggle");
  a_burst_min: assert property ($rose(dqsDevOe) |-> dqsDevOe[*4])
    else $error("burst shorter than four");
  a_burst_max: assert property (
    $rose(dqsDevOe) |-> ##[4:8] !dqsDevOe) else $error("burst too long");
  // Clock suspend freezes state; power-down only from idle
  a_cke_freeze: assert property (
    !cke && !$past(cke) |-> $stable(bankOpen) && $stable(dqsDevOe))
    else $error("state moved while clock suspended");
  a_pd_entry: assert property (
    $fell(cke) && bankOpen == '0 |=> powerDown)
    else $error("no power-down on idle clock-enable drop");
  a_pd_idle: assert property (
    $rose(powerDown) |-> $past(bankOpen) == '0 && !$past(cke))
    else $error("power-down with open bank");
  cover property ($rose(dqsDevOe));
  cover property ($rose(powerDown));
  cover property (cmd == CMD_ACT && cke);
endmodule

// ==== ddr3_link_if.sv ====
// Pin-level link between controller and DRAM device
`timescale 1ns/1ps
interface ddr3_link_if;
  import ddr3_link_pkg::*;
  logic ck;
  logic cke;
  logic csN;
  logic rasN;
  logic casN;
  logic weN;
  logic [BANK_W-1:0] ba;
  logic [ADDR_W-1:0] addr;
  logic [DQ_W-1:0] dqCtl;
  logic dqCtlOe;
  logic [DQ_W-1:0] dqDev;
  logic dqDevOe;
  logic dqsCtl;
  logic dqsCtlOe;
  logic dqsDev;
  logic dqsDevOe;
  logic [DQ_W-1:0] dq;
  logic dqs;
  // Resolve the shared data and strobe wires from the enables
  assign dq = dqDevOe ? dqDev : (dqCtlOe ? dqCtl : '0);
  assign dqs = dqsDevOe ? dqsDev : (dqsCtlOe ? dqsCtl : 1'b0);
  modport ctl (output ck, cke, csN, rasN, casN, weN, ba, addr,
               dqCtl, dqCtlOe, dqsCtl, dqsCtlOe, input dq, dqs);
  modport dev (input ck, cke, csN, rasN, casN, weN, ba, addr,
               output dqDev, dqDevOe, dqsDev, dqsDevOe, input dq, dqs);
endinterface

// ==== ddr3_link_pkg.sv ====
// Constants, types and operation summary for the DRAM command port link
// Operation
// - Inputs captured on rising link clock edge
// - Data moves on both strobe edges
// - Read data timed to both clock crossings (device launches read data on the rising link clock only)
// - CKE low freezes internal clock, outputs, burst
// - CKE drop while idle enters power-down
// - Three bank bits select target bank
// - Activate takes sixteen address bits as row
// - Column from A0-A9 plus A11 only
// - Mode set loads address as opcode
// - Additive latency zero, CL-1, or CL-2
// - Burst length four or eight beats
// - Sequential or interleaved beat order
// - Controller refreshes every 7.8 or 3.9 us (controller only raises a due flag; REF is issued through REG_CMD)
// - A10 auto-precharge or precharge all banks
// - A12 low chops burst to four (only when the MR0 burst field selects on-the-fly; fixed 8 ignores A12)
// - Chip select high masks all commands
// - RAS, CAS, WE decode the command
package ddr3_link_pkg;
  localparam int BANK_W = 3;
  localparam int ADDR_W = 16;
  localparam int COL_W = 11;
  localparam int DQ_W = 8;
  localparam int NUM_BANKS = 8;
  localparam int MR_NUM = 4;
  localparam int CAS_LAT = 11;
  localparam int BL_FULL = 8;
  localparam int BL_CHOP = 4;
  localparam int AP_BIT = 10;
  localparam int BC_BIT = 12;
  localparam int COL_HI_BIT = 11;
  // Mode register 0 fields used here
  localparam int MR0_BL_POS = 0;
  localparam int MR0_BT_POS = 3;
  // Mode register 1 additive latency field
  localparam int MR1_AL_POS = 3;
  localparam logic [1:0] AL_ZERO = 2'h0;
  localparam logic [1:0] AL_CL1 = 2'h1;
  localparam logic [1:0] AL_CL2 = 2'h2;
  localparam logic [15:0] MR_RESET = 16'h0000;
  // Refresh timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int REFI_NORM_NS = 7800;
  localparam int REFI_HOT_NS = 3900;
  localparam int REFI_NORM_CYC = REFI_NORM_NS * 1000 / CLK_PERIOD_PS;
  localparam int REFI_HOT_CYC = REFI_HOT_NS * 1000 / CLK_PERIOD_PS;
  // Link clock divider half period in controller clocks
  localparam int LINK_DIV_HALF = 5;
  // Register map of the controller
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h1;
  localparam logic [3:0] REG_WDATA = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_RDATA = 4'h4;
  localparam logic [3:0] REG_CTRL = 4'h5;
  // Command encodings on the pins {cs_n, ras_n, cas_n, we_n}
  typedef enum logic [3:0] {
    CMD_MRS = 4'h0,
    CMD_REF = 4'h1,
    CMD_PRE = 4'h2,
    CMD_ACT = 4'h3,
    CMD_WR = 4'h4,
    CMD_RD = 4'h5,
    CMD_NOP = 4'h7,
    CMD_DES = 4'h8
  } cmd_type;
  // Return column address from the address pins
  function automatic logic [COL_W-1:0] col_of(input logic [ADDR_W-1:0] a);
    col_of = {a[COL_HI_BIT], a[9:0]};
  endfunction
  // Beat index within a burst for the selected order
  function automatic logic [2:0] beat_idx(input logic [2:0] start,
                                          input logic [2:0] n,
                                          input logic ilv);
    beat_idx = ilv ? (start ^ n) : {start[2], start[1:0] + n[1:0]} ^
               {n[2], 2'h0};
  endfunction
endpackage

// ==== ddr3_mem_ctrl.sv ====
// Controller end: Avalon-MM registers, link clock divider, pin driver
//
// Our own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
module ddr3_mem_ctrl #(
  parameter int REFI_CYCLES = ddr3_link_pkg::REFI_NORM_CYC,
  parameter int REFI_HOT_CYCLES = ddr3_link_pkg::REFI_HOT_CYC
) (
  input wire logic clk, // System clock 200 MHz
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic [3:0] avsAddress, // Word address
  input wire logic avsRead, // Read request
  input wire logic avsWrite, // Write request
  input wire logic [31:0] avsWritedata, // Write data
  output logic [31:0] avsReaddata, // Read data
  output logic avsWaitrequest, // Stall
  ddr3_link_if.ctl link // Pins to the device
);
  import ddr3_link_pkg::*;
  typedef enum logic [1:0] {C_IDLE, C_ISSUE, C_HOLD} cst_type;
  cst_type state_q;
  logic [2:0] divCnt_q;
  logic ck_q;
  logic [3:0] cmdPin_q;
  logic [BANK_W-1:0] ba_q;
  logic [ADDR_W-1:0] addr_q;
  logic [3:0] pendCmd_q;
  logic [BANK_W-1:0] pendBa_q;
  logic [ADDR_W-1:0] pendAddr_q;
  logic [DQ_W-1:0] wdata_q;
  logic [DQ_W-1:0] rdata_q;
  logic cke_q;
  logic hot_q;
  logic refDue_q;
  logic [19:0] refCnt_q;
  logic wait_q;
  logic [31:0] rd_q;
  logic [1:0] dqsSync_q;
  logic [DQ_W-1:0] dqSync1_q;
  logic [DQ_W-1:0] dqSync2_q;
  wire busy = state_q != C_IDLE;
  // Pins change on link clock falling phase so the device sees stable levels
  wire ckFall = divCnt_q == 3'(LINK_DIV_HALF - 1) && ck_q;
  wire ckRise = divCnt_q == 3'(LINK_DIV_HALF - 1) && !ck_q;
  wire cmdWr = avsWrite && avsAddress == REG_CMD && !busy && !wait_q;
  wire [19:0] refLimit = hot_q ? 20'(REFI_HOT_CYCLES) : 20'(REFI_CYCLES);
  // Link clock divider
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      divCnt_q <= 3'h0;
      ck_q <= 1'b0;
    end else if (divCnt_q == 3'(LINK_DIV_HALF - 1)) begin
      divCnt_q <= 3'h0;
      ck_q <= ~ck_q;
    end else begin
      divCnt_q <= divCnt_q + 3'h1;
    end
  end
  // Refresh interval timer; due flag set wins over clear
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      refCnt_q <= 20'h0;
      refDue_q <= 1'b0;
    end else begin
      refCnt_q <= refCnt_q >= refLimit - 20'h1 ? 20'h0 : refCnt_q + 20'h1;
      if (refCnt_q >= refLimit - 20'h1)
        refDue_q <= 1'b1;
      else if (state_q == C_ISSUE && ckFall && pendCmd_q == CMD_REF)
        refDue_q <= 1'b0;
    end
  end
  // Command issue: one command for one link cycle, then deselect
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q <= C_IDLE;
      cmdPin_q <= CMD_DES;
      ba_q <= '0;
      addr_q <= '0;
      pendCmd_q <= CMD_DES;
      pendBa_q <= '0;
      pendAddr_q <= '0;
    end else begin
      unique case (state_q)
        C_IDLE: begin
          if (cmdWr) begin
            pendCmd_q <= avsWritedata[3:0];
            pendBa_q <= avsWritedata[6:4];
            state_q <= C_ISSUE;
          end
        end
        C_ISSUE: begin
          if (ckFall) begin
            cmdPin_q <= pendCmd_q;
            ba_q <= pendBa_q;
            addr_q <= pendAddr_q;
            state_q <= C_HOLD;
          end
        end
        C_HOLD: begin
          if (ckFall) begin
            cmdPin_q <= CMD_DES;
            state_q <= C_IDLE;
          end
        end
        default: state_q <= C_IDLE;
      endcase
      if (avsWrite && avsAddress == REG_ADDR && !busy && !wait_q)
        pendAddr_q <= avsWritedata[ADDR_W-1:0];
    end
  end
  // Control register, write data and read data capture
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cke_q <= 1'b1;
      hot_q <= 1'b0;
      wdata_q <= '0;
      rdata_q <= '0;
      dqsSync_q <= 2'h0;
      dqSync1_q <= '0;
      dqSync2_q <= '0;
    end else begin
      dqsSync_q <= {dqsSync_q[0], link.dqs};
      dqSync1_q <= link.dq;
      dqSync2_q <= dqSync1_q;
      if (dqsSync_q[1])
        rdata_q <= dqSync2_q;
      if (avsWrite && avsAddress == REG_CTRL && !wait_q) begin
        cke_q <= avsWritedata[0];
        hot_q <= avsWritedata[1];
      end
      if (avsWrite && avsAddress == REG_WDATA && !wait_q)
        wdata_q <= avsWritedata[DQ_W-1:0];
    end
  end
  // Avalon slave: one wait cycle on every access, fixed latency
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wait_q <= 1'b1;
      rd_q <= 32'h0;
    end else begin
      wait_q <= !(avsRead || avsWrite) || !wait_q;
      unique case (avsAddress)
        REG_STATUS: rd_q <= {29'h0, refDue_q, cke_q, busy};
        REG_RDATA: rd_q <= {24'h0, rdata_q};
        REG_CTRL: rd_q <= {30'h0, hot_q, cke_q};
        REG_ADDR: rd_q <= {16'h0, pendAddr_q};
        default: rd_q <= 32'h0;
      endcase
    end
  end
  assign avsReaddata = rd_q;
  assign avsWaitrequest = wait_q;
  assign link.ck = ck_q;
  assign link.cke = cke_q;
  assign {link.csN, link.rasN, link.casN, link.weN} = cmdPin_q;
  assign link.ba = ba_q;
  assign link.addr = addr_q;
  assign link.dqCtl = wdata_q;
  assign link.dqCtlOe = 1'b1;
  assign link.dqsCtl = ck_q;
  assign link.dqsCtlOe = 1'b0;
endmodule

// ==== test_ddr3_sdram_command_address_port.sv ====
// Testbench: controller and device joined, driven over Avalon-MM
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module test_ddr3_sdram_command_address_port;
  import ddr3_link_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic resetLinkN = 1'b0;
  logic [3:0] avsAddress = 4'h0;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [31:0] avsWritedata = 32'h0;
  logic [31:0] avsReaddata;
  logic avsWaitrequest;
  logic [7:0] bankOpen;
  logic powerDown;
  logic [31:0] rd = 32'h0;
  logic oePrev = 1'b0;
  logic done = 1'b0;
  int fails = 0;
  int n_checks = 0;
  int linkCyc = 0;
  int rdAt = 0;
  int lat = 0;
  int beats = 0;
  // Mode settings per burst case: MR0, MR1, address, beats, latency
  logic [15:0] mr0T [4] = '{16'h0, 16'h2, 16'h1, 16'h9};
  logic [15:0] mr1T [4] = '{16'h8, 16'h10, 16'h0, 16'h0};
  logic [15:0] colT [4] = '{16'h1005, 16'h1005, 16'h0005, 16'h1005};
  int beatT [4] = '{8, 4, 4, 8};
  int latT [4] = '{2 * CAS_LAT - 1, 2 * CAS_LAT - 2, CAS_LAT, CAS_LAT};
  ddr3_link_if link();
  // ====
  // Clock
  always #2.5 clk = ~clk;
  // Short refresh interval keeps the run brief
  ddr3_mem_ctrl #(.REFI_CYCLES(50), .REFI_HOT_CYCLES(25)) ddr3_mem_ctrl_inst (
    .clk(clk), .reset_n(reset_n), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWritedata(avsWritedata),
    .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest),
    .link(link));
  ddr3_dram_device ddr3_dram_device_inst (.resetLinkN(resetLinkN),
    .link(link), .bankOpen(bankOpen), .powerDown(powerDown));
  ddr3_link_chk ddr3_link_chk_inst (.ck(link.ck), .resetLinkN(resetLinkN),
    .cke(link.cke), .csN(link.csN), .rasN(link.rasN), .casN(link.casN),
    .weN(link.weN), .ba(link.ba), .addr(link.addr), .dqs(link.dqs),
    .dqsDevOe(link.dqsDevOe), .bankOpen(bankOpen), .powerDown(powerDown));
  // ====
  // Read monitor: latency from command sample to first beat, beat count
  always @(posedge link.ck) begin
    linkCyc++;
    if ({link.csN, link.rasN, link.casN, link.weN} == CMD_RD && link.cke)
      rdAt = linkCyc;
    if (link.dqsDevOe && !oePrev) begin
      lat = linkCyc - rdAt - 1; // Beat is seen one edge after launch
      beats = 0;
    end
    if (link.dqsDevOe) beats++;
    if (!link.dqsDevOe && oePrev) done = 1'b1;
    oePrev = link.dqsDevOe;
  end
  // One Avalon transfer, held until waitrequest is sampled low
  task automatic avXfer(input logic wr, input logic [3:0] a,
                        input logic [31:0] d);
    int n;
    n = 0;
    avsAddress <= a;
    avsWritedata <= d;
    avsWrite <= wr;
    avsRead <= !wr;
    do begin
      @(posedge clk);
      n++;
    end while (avsWaitrequest !== 1'b0 && n < 50);
    if (avsWaitrequest !== 1'b0) fails++;
    rd = avsReaddata;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    @(posedge clk);
  endtask
  // Command on the pins; the wait lets busy cross before polling
  task automatic issue(input logic [3:0] c, input logic [2:0] b,
                       input logic [15:0] a);
    int n;
    avXfer(1'b1, REG_ADDR, {16'h0, a});
    avXfer(1'b1, REG_CMD, {25'h0, b, c});
    repeat (30) @(posedge clk);
    avXfer(1'b0, REG_STATUS, 32'h0);
    for (n = 0; n < 40 && rd[0] !== 1'b0; n++)
      avXfer(1'b0, REG_STATUS, 32'h0);
    if (rd[0] !== 1'b0) fails++;
  endtask
  // Read burst, then fetch the last captured byte
  task automatic readBurst(input logic [2:0] b, input logic [15:0] a);
    int n;
    done = 1'b0;
    issue(CMD_RD, b, a);
    for (n = 0; n < 800 && !done; n++) @(posedge clk);
    repeat (20) @(posedge clk);
    avXfer(1'b0, REG_RDATA, 32'h0);
  endtask
  task automatic conclude();
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Watchdog against a hung handshake
  initial begin
    #300000;
    fails++;
    conclude();
  end
  // ====
  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    repeat (48) @(posedge clk);
    resetLinkN <= 1'b1;
    repeat (30) @(posedge clk);
    avXfer(1'b0, REG_STATUS, 32'h0);
    `CHK(rd[1:0], 2'b10)
    avXfer(1'b0, 4'hf, 32'h0);
    `CHK(rd, 32'h0)
    issue(CMD_MRS, 3'h1, 16'h0);
    issue(CMD_MRS, 3'h0, 16'h0);
    issue(CMD_ACT, 3'h3, 16'h1234);
    `CHK(bankOpen, 8'h08)
    issue(4'hb, 3'h5, 16'h0);
    `CHK(bankOpen, 8'h08)
    // Write with non-column lines set, read back through plain column
    avXfer(1'b1, REG_WDATA, 32'ha5);
    issue(CMD_WR, 3'h3, 16'hf005);
    // Let the write burst finish before the bus data changes
    repeat (250) @(posedge clk);
    avXfer(1'b1, REG_WDATA, 32'h3c);
    readBurst(3'h3, 16'h1005);
    `CHK(rd[7:0], 8'ha5)
    `CHK(beats, BL_FULL)
    `CHK(lat, CAS_LAT)
    for (int i = 0; i < 4; i++) begin
      issue(CMD_PRE, 3'h0, 16'h0400);
      issue(CMD_MRS, 3'h0, mr0T[i]);
      issue(CMD_MRS, 3'h1, mr1T[i]);
      issue(CMD_ACT, 3'h3, 16'h1234);
      readBurst(3'h3, colT[i]);
      `CHK(rd[7:0], 8'ha5)
      `CHK(beats, beatT[i])
      `CHK(lat, latT[i])
    end
    issue(CMD_ACT, 3'h1, 16'h0);
    issue(CMD_ACT, 3'h2, 16'h0);
    `CHK(bankOpen, 8'h0e)
    issue(CMD_PRE, 3'h1, 16'h0);
    `CHK(bankOpen, 8'h0c)
    readBurst(3'h2, 16'h1405);
    `CHK(bankOpen, 8'h08)
    issue(CMD_PRE, 3'h5, 16'h0400);
    `CHK(bankOpen, 8'h00)
    avXfer(1'b1, REG_CTRL, 32'h0);
    repeat (40) @(posedge clk);
    `CHK(powerDown, 1'b1)
    avXfer(1'b0, REG_STATUS, 32'h0);
    `CHK(rd[1], 1'b0)
    avXfer(1'b1, REG_CTRL, 32'h3);
    repeat (40) @(posedge clk);
    `CHK(powerDown, 1'b0)
    avXfer(1'b0, REG_STATUS, 32'h0);
    `CHK(rd[2], 1'b1)
    conclude();
  end
endmodule
